// [adc_device_end.sv]
`default_nettype none
module adc_device_end
  import adc_link_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_LINK_CYCLES
) (
  adc_link_if.device link,
  input wire logic rst,
  input wire logic ce,
  input wire logic [DATA_W-1:0] analog_in,
  output logic power_down,
  output logic converting,
  output logic daisy_mode
);
  ////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic trig_s;
  logic sdi_s;
  logic sclk_s;
  logic trig_q_ff;
  logic sclk_q_ff;
  logic sel_low_q_ff;
  logic sel_low;
  logic trig_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;

  sync2 #(
    .W(3)
  ) u_pin_sync (
    .clk(link.link_clk),
    .rst(rst),
    .ce(ce),
    .d({link.conversion_trigger, link.sdi, link.sclk}),
    .q({trig_s, sdi_s, sclk_s})
  );

  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      trig_q_ff <= TRIG_RESET;
      sclk_q_ff <= SCLK_RESET;
      sel_low_q_ff <= 1'b1;
    end else if (ce) begin
      trig_q_ff <= trig_s;
      sclk_q_ff <= sclk_s;
      sel_low_q_ff <= sel_low;
    end
  end

  // Only one select line is in use per wiring, the other idles high
  assign sel_low = ~(trig_s & sdi_s);
  assign trig_rise = trig_s & ~trig_q_ff;
  assign sclk_fall = ~sclk_s & sclk_q_ff;
  assign sel_fall = sel_low & ~sel_low_q_ff;
  assign sel_rise = ~sel_low & sel_low_q_ff;

  ////////////////////////////////////////////////
  // Conversion sequencing

  dev_state_t state_ff;
  logic [15:0] conv_cnt_ff;
  logic [DATA_W-1:0] sample_ff;
  logic daisy_ff;
  logic power_down_ff;
  logic converting_ff;
  logic conv_done;
  logic start_conv;

  assign start_conv = (state_ff == DEV_ACQ) && trig_rise;
  assign conv_done = (state_ff == DEV_CONV) && (conv_cnt_ff == 16'(CONV_CYCLES - 1));

  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      state_ff <= DEV_ACQ;
      conv_cnt_ff <= 16'h0000;
      sample_ff <= '0;
      daisy_ff <= 1'b0;
      power_down_ff <= 1'b1;
    end else if (ce) begin
      case (state_ff)
        DEV_ACQ: begin
          if (start_conv) begin
            state_ff <= DEV_CONV;
            conv_cnt_ff <= 16'h0000;
            // Input code is stored unchanged; no signed or offset conversion is made
            sample_ff <= analog_in;
            daisy_ff <= ~sdi_s;
            power_down_ff <= 1'b0;
          end
        end
        DEV_CONV: begin
          // Runs on the internal count only; select pins are not looked at
          if (conv_done) begin
            state_ff <= DEV_ACQ;
            power_down_ff <= 1'b1;
          end else begin
            conv_cnt_ff <= conv_cnt_ff + 16'h0001;
          end
        end
        default: begin
          state_ff <= DEV_ACQ;
        end
      endcase
    end
  end

  // Status flop of its own, so the output carries no gate after the register
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      converting_ff <= 1'h0;
    end else if (ce) begin
      if (start_conv) begin
        converting_ff <= 1'h1;
      end else if (conv_done) begin
        converting_ff <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////
  // Serial output

  logic [DATA_W:0] shift_ff;
  logic [4:0] fall_cnt_ff;
  logic [4:0] limit_ff;
  logic armed_ff;
  logic oe_n_ff;
  logic [4:0] nxt_fall_cnt;

  assign nxt_fall_cnt = fall_cnt_ff + 5'h01;

  // Daisy-chain readout is not built: in that mode the line stays floating
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= '0;
      fall_cnt_ff <= 5'h00;
      limit_ff <= BITS_PLAIN;
      armed_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      if (start_conv) begin
        oe_n_ff <= 1'b1;
        armed_ff <= 1'b0;
      end else if (conv_done && !daisy_ff) begin
        fall_cnt_ff <= 5'h00;
        if (sel_low) begin
          // Low busy bit leads, data follows on the next falls
          shift_ff <= {1'b0, sample_ff};
          limit_ff <= BITS_BUSY;
          oe_n_ff <= 1'b0;
          armed_ff <= 1'b0;
        end else begin
          shift_ff <= {sample_ff, 1'b0};
          limit_ff <= BITS_PLAIN;
          armed_ff <= 1'b1;
        end
      end else if (sel_rise) begin
        oe_n_ff <= 1'b1;
        armed_ff <= 1'b0;
      end else if (sel_fall && armed_ff) begin
        oe_n_ff <= 1'b0;
        armed_ff <= 1'b0;
      end else if (sclk_fall && !oe_n_ff) begin
        // Bit changes only on a fall, so it stands across the next rise
        shift_ff <= {shift_ff[DATA_W-1:0], 1'b0};
        fall_cnt_ff <= nxt_fall_cnt;
        if (nxt_fall_cnt == limit_ff) begin
          oe_n_ff <= 1'b1;
        end
      end
    end
  end

  assign link.sdo = shift_ff[DATA_W];
  assign link.sdo_oe_n = oe_n_ff;
  assign power_down = power_down_ff;
  assign converting = converting_ff;
  assign daisy_mode = daisy_ff;
endmodule
`default_nettype wire

// [adc_host_end.sv]
`default_nettype none
module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int WAIT_CYCLES = HOST_WAIT_CYCLES,
  parameter int HOLD_CYCLES = SEL_HOLD_CYCLES,
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  adc_link_if.host link,
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic four_wire,
  input wire logic use_busy,
  output logic [DATA_W-1:0] result,
  output logic result_valid,
  output logic busy
);
  ////////////////////////////////////////////////
  // Data line synchroniser

  logic sdo_s;

  sync2 #(
    .W(1)
  ) u_sdo_sync (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .d(link.sdo_line),
    .q(sdo_s)
  );

  ////////////////////////////////////////////////
  // Conversion and readout sequence

  host_state_t state_ff;
  logic [15:0] tmr_ff;
  logic trig_ff;
  logic sdi_ff;
  logic sclk_ff;
  logic four_ff;
  logic bm_ff;
  logic [4:0] bits_ff;
  logic [DATA_W:0] shift_ff;
  logic [DATA_W-1:0] result_ff;
  logic valid_ff;
  logic busy_ff;
  logic [4:0] nbits;

  assign nbits = bm_ff ? BITS_BUSY : BITS_PLAIN;

  // Idle levels: trigger low, serial input high, so both are never low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= H_IDLE;
      tmr_ff <= 16'h0000;
      trig_ff <= TRIG_RESET;
      sdi_ff <= SDI_RESET;
      sclk_ff <= SCLK_RESET;
      four_ff <= 1'b0;
      bm_ff <= 1'b0;
      bits_ff <= 5'h00;
      shift_ff <= '0;
      result_ff <= '0;
      valid_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        H_IDLE: begin
          valid_ff <= 1'b0;
          if (start) begin
            four_ff <= four_wire;
            bm_ff <= use_busy;
            trig_ff <= 1'b1;
            tmr_ff <= 16'h0000;
            busy_ff <= 1'b1;
            state_ff <= H_TRIG;
          end
        end
        H_TRIG: begin
          tmr_ff <= tmr_ff + 16'h0001;
          if (tmr_ff == 16'(HOLD_CYCLES - 1)) begin
            tmr_ff <= 16'h0000;
            state_ff <= H_CONV;
            // Busy option: drop the select well before the minimum time
            if (bm_ff && four_ff) begin
              sdi_ff <= 1'b0;
            end else if (bm_ff) begin
              trig_ff <= 1'b0;
            end
          end
        end
        H_CONV: begin
          tmr_ff <= tmr_ff + 16'h0001;
          // Plain option: select stays high through the whole window
          if (tmr_ff == 16'(WAIT_CYCLES - 1)) begin
            tmr_ff <= 16'h0000;
            bits_ff <= 5'h00;
            state_ff <= H_SHIFT;
            if (!bm_ff && four_ff) begin
              sdi_ff <= 1'b0;
            end else if (!bm_ff) begin
              trig_ff <= 1'b0;
            end
          end
        end
        H_SHIFT: begin
          tmr_ff <= tmr_ff + 16'h0001;
          if (tmr_ff == 16'(HALF_CYCLES - 1)) begin
            tmr_ff <= 16'h0000;
            if (!sclk_ff) begin
              // Captured late in the low phase, before the rising edge
              shift_ff <= {shift_ff[DATA_W-1:0], sdo_s};
              bits_ff <= bits_ff + 5'h01;
              sclk_ff <= 1'b1;
            end else begin
              sclk_ff <= 1'b0;
              if (bits_ff == nbits) begin
                state_ff <= H_END;
              end
            end
          end
        end
        H_END: begin
          // Last fall is out; the device floats the line within three link edges of it, and in four-wire mode the select is released here
          result_ff <= shift_ff[DATA_W-1:0];
          valid_ff <= 1'b1;
          busy_ff <= 1'b0;
          sdi_ff <= 1'b1;
          state_ff <= H_DROP;
        end
        H_DROP: begin
          valid_ff <= 1'b0;
          trig_ff <= 1'b0;
          state_ff <= H_IDLE;
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  assign link.conversion_trigger = trig_ff;
  assign link.sdi = sdi_ff;
  assign link.sclk = sclk_ff;
  assign result = result_ff;
  assign result_valid = valid_ff;
  assign busy = busy_ff;
endmodule
`default_nettype wire

// [adc_link_if.sv]
`default_nettype none
interface adc_link_if (
  input wire logic link_clk
);
  logic conversion_trigger;
  logic sdi;
  logic sclk;
  logic sdo;
  logic sdo_oe_n;
  logic sdo_line;
  // Pull-up on the data line while the device lets it float
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
  modport device (
    input link_clk,
    input conversion_trigger,
    input sdi,
    input sclk,
    output sdo,
    output sdo_oe_n
  );
  modport host (
    output conversion_trigger,
    output sdi,
    output sclk,
    input sdo_line
  );
endinterface
`default_nettype wire

// [adc_link_pkg.sv]
`default_nettype none
package adc_link_pkg;
  localparam int DATA_W = 16;
  localparam int REF_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 32;
  localparam int TCONV_MIN_NS = 1000;
  localparam int TCONV_MAX_NS = 1400;
  localparam int SEL_HOLD_NS = 120;
  localparam int SCLK_HALF_NS = 160;
  // Device finishes no earlier than the minimum conversion time
  localparam int CONV_LINK_CYCLES = (TCONV_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int TCONV_MAX_CYCLES = (TCONV_MAX_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  // Extra wait covers the device's input synchronisers and detect stage
  localparam int SYNC_SLACK_CYCLES = (4 * LINK_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int HOST_WAIT_CYCLES = TCONV_MAX_CYCLES + SYNC_SLACK_CYCLES;
  localparam int SEL_HOLD_CYCLES = (SEL_HOLD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [4:0] BITS_PLAIN = 5'h10;
  localparam logic [4:0] BITS_BUSY = 5'h11;
  localparam logic TRIG_RESET = 1'h0;
  localparam logic SDI_RESET = 1'h1;
  localparam logic SCLK_RESET = 1'h0;
  typedef enum logic {DEV_ACQ, DEV_CONV} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_TRIG, H_CONV, H_SHIFT, H_END, H_DROP} host_state_t;
endpackage
`default_nettype wire

// [adc_link_sva.sv]
`default_nettype none
module adc_link_sva (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic conversion_trigger,
  input wire logic sdi,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_ff;
  logic [4:0] fall_cnt_ff;
  logic sel;
  assign sel = conversion_trigger & sdi;
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sclk_ff <= 1'b0;
    end else begin
      sclk_ff <= sclk;
    end
  end
  // Counts falls of a frame only, so a floated line restarts from zero
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      fall_cnt_ff <= 5'h00;
    end else if (sdo_oe_n) begin
      fall_cnt_ff <= 5'h00;
    end else if (sclk_ff && !sclk) begin
      fall_cnt_ff <= fall_cnt_ff + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////
  a_trig_float: assert property ($rose(conversion_trigger) |-> ##[0:3] sdo_oe_n)
    else $error("line not floated after trigger rise");
  a_conv_quiet: assert property ($rose(conversion_trigger) |-> ##4 sdo_oe_n [*4])
    else $error("line driven during conversion");
  a_sel_pair: assert property (conversion_trigger || sdi)
    else $error("trigger and serial input low together");
  a_desel_float: assert property (sel [*4] |-> sdo_oe_n)
    else $error("line driven while deselected");
  a_drive_on_sel: assert property ($fell(sdo_oe_n) |-> !sel && !sclk)
    else $error("line driven without select or with clock high");
  a_busy_low_first: assert property ($fell(sdo_oe_n) && !$past(sel, 4) |-> !sdo)
    else $error("busy bit not low");
  a_bit_stable: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo) |-> !sclk)
    else $error("data bit changed while shift clock high");
  a_count_float: assert property (fall_cnt_ff == 5'h11 |-> ##[0:4] sdo_oe_n)
    else $error("line still driven after seventeenth fall");
  cover property ($fell(sdo_oe_n) && !$past(sel, 4));
  cover property (fall_cnt_ff == 5'h10);
  cover property (!conversion_trigger && !sdo_oe_n && !sdo_line);
endmodule
`default_nettype wire

// [adc_select_mode_serial_readout_tb.sv]
`default_nettype none
module adc_select_mode_serial_readout_tb
  import adc_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic four_wire = 1'b0;
  logic use_busy = 1'b0;
  logic [DATA_W-1:0] analog_in = 16'h0000;
  logic [DATA_W-1:0] result;
  logic result_valid, busy, power_down, converting, daisy_mode, daisy2;
  logic [DATA_W-1:0] vals [4] = '{16'h8001, 16'h7ffe, 16'ha5c3, 16'h3c5a};
  int err_count = 0;
  int num_checks = 0;
  adc_link_if link (.link_clk(link_clk));
  adc_link_if link2 (.link_clk(link_clk));
  ////////////////////////////////////////////////////////////////////
  adc_device_end #(.CONV_CYCLES(8)) adc_device_end_inst (.link(link.device), .rst(rst),
    .ce(ce), .analog_in(analog_in), .power_down(power_down), .converting(converting),
    .daisy_mode(daisy_mode));
  // Host wait must outlast 8 link cycles plus the device synchronisers
  adc_host_end #(.WAIT_CYCLES(40)) adc_host_end_inst (.link(link.host), .ref_clk(ref_clk),
    .rst(rst), .ce(ce), .start(start), .four_wire(four_wire), .use_busy(use_busy),
    .result(result), .result_valid(result_valid), .busy(busy));
  // Second end driven by hand to pick the other mode on purpose
  adc_device_end #(.CONV_CYCLES(8)) fault_device_inst (.link(link2.device), .rst(rst),
    .ce(ce), .analog_in(analog_in), .power_down(), .converting(), .daisy_mode(daisy2));
  adc_link_sva adc_link_sva_inst (.link_clk(link_clk), .rst(rst),
    .conversion_trigger(link.conversion_trigger), .sdi(link.sdi), .sclk(link.sclk),
    .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));
  ////////////////////////////////////////////////////////////////////
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_word(input string name, input logic [DATA_W-1:0] exp,
    input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic run_mode(input logic fw, input logic ub, input logic [DATA_W-1:0] val);
    int n;
    n = 0;
    @(posedge ref_clk);
    start <= 1'b1;
    four_wire <= fw;
    use_busy <= ub;
    analog_in <= val;
    @(posedge ref_clk);
    start <= 1'b0;
    while (converting !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check_bit("conversion started", 1'b1, converting);
    check_bit("line floated in conversion", 1'b1, link.sdo_oe_n);
    check_bit("host busy", 1'b1, busy);
    n = 0;
    while (result_valid !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check_bit("result valid", 1'b1, result_valid);
    check_word("result word", val, result);
    check_bit("acquisition", 1'b1, power_down);
    check_bit("select mode", 1'b0, daisy_mode);
    check_bit("host idle", 1'b0, busy);
    // Device floats up to three link edges after the last fall
    tick(16);
    check_bit("line floated after readout", 1'b1, link.sdo_oe_n);
    $display("test mode four_wire=%0b busy=%0b done", fw, ub);
  endtask
  task automatic daisy_test();
    @(posedge ref_clk);
    link2.sdi <= 1'b0;
    repeat (20) @(posedge ref_clk);
    link2.conversion_trigger <= 1'b1;
    tick(60);
    check_bit("daisy detect", 1'b1, daisy2);
    @(posedge ref_clk);
    link2.conversion_trigger <= 1'b0;
    tick(20);
    check_bit("daisy line released", 1'b1, link2.sdo_line);
    @(posedge ref_clk);
    link2.sdi <= 1'b1;
    repeat (20) @(posedge ref_clk);
    link2.conversion_trigger <= 1'b1;
    tick(60);
    check_bit("select mode again", 1'b0, daisy2);
    $display("test mode choice done");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    link2.conversion_trigger = 1'b0;
    link2.sdi = 1'b1;
    link2.sclk = 1'b0;
    // Reset is asynchronous here, and one rising link edge falls inside it
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      run_mode(i[1], i[0], vals[i]);
    end
    daisy_test();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("timeout waiting for tests");
    finish_test();
  end
endmodule
`default_nettype wire

// [sync2.sv]
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      hold_ff <= meta_ff;
    end
  end

  assign q = hold_ff;
endmodule
`default_nettype wire
